/* File: logic/bms_mem_if.sv */
/*
  Word port between the bus front ends and a memory array.
  Assumes the memory answers a read one clock after req.
*/
`timescale 1ns/1ps
interface bms_mem_if #(
  parameter int AW = 10,
  parameter int DW = 32
);
  logic req;
  logic we;
  logic [AW-1:0] idx;
  logic [DW-1:0] wdata;
  logic [DW/8-1:0] be;
  logic [DW-1:0] rdata;

  modport ctrl(output req, output we, output idx, output wdata, output be,
               input rdata);
  modport mem(input req, input we, input idx, input wdata, input be,
              output rdata);
endinterface

/* File: logic/bms_pkg.sv */
/*
  Shared constants, types and helper functions of the bus memory slave.
  Assumes byte addresses of 32 bits on both the TileLink and AXI4-Lite ports.
*/
package bms_pkg;

  // TileLink A-channel opcodes, uncached-lightweight plus atomics
  localparam logic [2:0] BMS_A_PUT_FULL = 3'h0;
  localparam logic [2:0] BMS_A_PUT_PART = 3'h1;
  localparam logic [2:0] BMS_A_ARITH = 3'h2;
  localparam logic [2:0] BMS_A_LOGIC = 3'h3;
  localparam logic [2:0] BMS_A_GET = 3'h4;

  // TileLink D-channel opcodes
  localparam logic [2:0] BMS_D_ACK = 3'h0;
  localparam logic [2:0] BMS_D_ACK_DATA = 3'h1;

  // arithmetic and logical atomic parameters
  localparam logic [2:0] BMS_AR_MIN = 3'h0;
  localparam logic [2:0] BMS_AR_MAX = 3'h1;
  localparam logic [2:0] BMS_AR_MINU = 3'h2;
  localparam logic [2:0] BMS_AR_MAXU = 3'h3;
  localparam logic [2:0] BMS_AR_ADD = 3'h4;
  localparam logic [2:0] BMS_LG_XOR = 3'h0;
  localparam logic [2:0] BMS_LG_OR = 3'h1;
  localparam logic [2:0] BMS_LG_AND = 3'h2;
  localparam logic [2:0] BMS_LG_SWAP = 3'h3;

  // AXI response codes
  localparam logic [1:0] BMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BMS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] BMS_RESP_DECERR = 2'h3;

  // values after reset
  localparam logic BMS_RST_READY = 1'b1;
  localparam logic BMS_RST_VALID = 1'b0;

  typedef enum logic [1:0] {
    BMS_TL_IDLE = 2'b00,
    BMS_TL_READ = 2'b01,
    BMS_TL_RESP = 2'b10
  } bms_tl_state_type;

  function automatic logic bms_in_range(input logic [31:0] addr,
                                        input logic [31:0] base,
                                        input logic [31:0] size);
    return (addr >= base) && ((addr - base) < size);
  endfunction

  // read-only contents source: byte i of the region holds i
  function automatic logic [7:0] bms_rom_byte(input logic [31:0] byteIdx);
    return byteIdx[7:0];
  endfunction

endpackage

/* File: logic/bms_rom.sv */
/*
  Read-only word memory filled from the package contents source.
  Assumes the controller never asks it to write; write fields are ignored.
*/
`timescale 1ns/1ps
module bms_rom
  import bms_pkg::*;
#(
  parameter int AW = 4,
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  bms_mem_if.mem port
);
  localparam int WB = DW / 8;

  if (DW % 8 != 0) begin : g_bad_dw
    $error("data width must be whole bytes");
  end

  logic [DW-1:0] rdata_q;
  logic [DW-1:0] word;

  // contents come from a function of the byte index, fixed at build time
  always_comb begin
    word = '0;
    for (int b = 0; b < WB; b++) begin
      word[8*b +: 8] = bms_rom_byte(32'(port.idx) * 32'(WB) + 32'(b));
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (port.req) begin
      rdata_q <= word;
    end
  end

  assign port.rdata = rdata_q;
endmodule

/* File: logic/bms_sram.sv */
/*
  Single-port word memory with byte enables and registered read data.
  Assumes one request per clock from a single controller.
*/
`timescale 1ns/1ps
module bms_sram #(
  parameter int AW = 10,
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  bms_mem_if.mem port
);
  logic [DW-1:0] store [2**AW];
  logic [DW-1:0] rdata_q;

  if (DW % 8 != 0) begin : g_bad_dw
    $error("data width must be whole bytes");
  end

  // all lanes in one process so the array has a single writer
  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < DW / 8; b++) begin
      if (port.req && port.we && port.be[b]) begin
        store[port.idx][8*b +: 8] <= port.wdata[8*b +: 8];
      end
    end
  end

  // read-before-write: a write returns the old word; atomics take theirs from a read in the cycle before
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (port.req) begin
      rdata_q <= store[port.idx];
    end
  end

  assign port.rdata = rdata_q;
endmodule

/* File: logic/bms_top.sv */
/*
  Bus memory slave: a TileLink port serving a read-write memory and a
  read-only memory, and an AXI4-Lite port serving a second read-write memory.
  Assumes one clock and one asynchronous active-low reset for both ports.
*/
// Overview of operation
// - read-write memory serves only addresses inside its parameter range
// - data path width is the interface width parameter in bytes, 4 default
// - TileLink memory takes only single-beat lightweight requests
// - with the atomics option on, arithmetic and logical atomics execute
// - AXI memory handles AXI4-Lite only, never multi-beat bursts
// - memory advertises cacheable and executable attributes, both true
// - read-only memory is readable over TileLink and never changes
// - read-only memory serves only single-beat reads
// - read-only region has a base, byte size and generated contents
// - read-only width parameter defaults to 4; executable attribute true
`timescale 1ns/1ps
module bms_top
  import bms_pkg::*;
#(
  parameter int unsigned WIDTH_BYTES = 4,
  parameter logic [31:0] TLRAM_BASE = 32'h0000_1000,
  parameter logic [31:0] TLRAM_SIZE = 32'h0000_1000,
  parameter logic [31:0] AXIRAM_BASE = 32'h0000_2000,
  parameter logic [31:0] AXIRAM_SIZE = 32'h0000_1000,
  parameter logic [31:0] ROM_BASE = 32'h100a_0000,
  parameter logic [31:0] ROM_SIZE = 32'h0000_0040,
  parameter bit ATOMICS = 1'b0,
  parameter bit CACHEABLE = 1'b1,
  parameter bit RAM_EXECUTABLE = 1'b1,
  parameter bit ROM_EXECUTABLE = 1'b1,
  parameter int SRC_W = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic a_valid,
  output logic a_ready,
  input wire logic [2:0] a_opcode,
  input wire logic [2:0] a_param,
  input wire logic [2:0] a_size,
  input wire logic [SRC_W-1:0] a_source,
  input wire logic [31:0] a_address,
  input wire logic [WIDTH_BYTES-1:0] a_mask,
  input wire logic [8*WIDTH_BYTES-1:0] a_data,
  output logic d_valid,
  input wire logic d_ready,
  output logic [2:0] d_opcode,
  output logic [2:0] d_size,
  output logic [SRC_W-1:0] d_source,
  output logic d_denied,
  output logic d_corrupt,
  output logic [8*WIDTH_BYTES-1:0] d_data,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [8*WIDTH_BYTES-1:0] wdata,
  input wire logic [WIDTH_BYTES-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [8*WIDTH_BYTES-1:0] rdata,
  output logic [1:0] rresp,
  output logic ramCacheable,
  output logic ramExecutable,
  output logic romExecutable
);
  localparam int DW = 8 * WIDTH_BYTES;
  localparam int LGW = $clog2(WIDTH_BYTES);
  localparam int TLRAM_AW = $clog2(TLRAM_SIZE / WIDTH_BYTES);
  localparam int AXIRAM_AW = $clog2(AXIRAM_SIZE / WIDTH_BYTES);
  localparam int ROM_AW = $clog2(ROM_SIZE / WIDTH_BYTES);
  localparam logic [WIDTH_BYTES-1:0] FULL_STRB = '1;

  generate
    if (WIDTH_BYTES != 4 && WIDTH_BYTES != 8) begin : g_bad_width
      $error("interface width must be 4 or 8 bytes");
    end
    if (TLRAM_SIZE < WIDTH_BYTES || AXIRAM_SIZE < WIDTH_BYTES ||
        ROM_SIZE < WIDTH_BYTES) begin : g_bad_size
      $error("memory sizes must hold at least one word");
    end
  endgenerate

  // signed compares use the whole word, so partial-mask min/max are
  // only meaningful when the mask covers the full word
  function automatic logic [DW-1:0] atomicResult(input logic [2:0] op,
                                                 input logic [2:0] prm,
                                                 input logic [DW-1:0] old,
                                                 input logic [DW-1:0] arg);
    logic [DW-1:0] res;
    res = arg;
    if (op == BMS_A_ARITH) begin
      unique case (prm)
        BMS_AR_MIN: res = ($signed(old) < $signed(arg)) ? old : arg;
        BMS_AR_MAX: res = ($signed(old) > $signed(arg)) ? old : arg;
        BMS_AR_MINU: res = (old < arg) ? old : arg;
        BMS_AR_MAXU: res = (old > arg) ? old : arg;
        BMS_AR_ADD: res = old + arg;
        default: res = old;
      endcase
    end else begin
      unique case (prm)
        BMS_LG_XOR: res = old ^ arg;
        BMS_LG_OR: res = old | arg;
        BMS_LG_AND: res = old & arg;
        BMS_LG_SWAP: res = arg;
        default: res = old;
      endcase
    end
    return res;
  endfunction

  bms_mem_if #(.AW(TLRAM_AW), .DW(DW)) tlRamBus();
  bms_mem_if #(.AW(ROM_AW), .DW(DW)) romBus();
  bms_mem_if #(.AW(AXIRAM_AW), .DW(DW)) axiRamBus();

  bms_sram #(.AW(TLRAM_AW), .DW(DW)) uTlRam (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .port(tlRamBus.mem)
  );

  bms_rom #(.AW(ROM_AW), .DW(DW)) uRom (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .port(romBus.mem)
  );

  bms_sram #(.AW(AXIRAM_AW), .DW(DW)) uAxiRam (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .port(axiRamBus.mem)
  );

  // TileLink side
  bms_tl_state_type tlState_q, tlState_d;
  logic aReady_q, aReady_d, dValid_q, dValid_d;
  logic [2:0] dOpcode_q, dSize_q, op_q, param_q;
  logic [SRC_W-1:0] dSource_q;
  logic dDenied_q, dCorrupt_q, isRom_q;
  logic [DW-1:0] dData_q, operand_q;
  logic [WIDTH_BYTES-1:0] mask_q;
  logic [TLRAM_AW-1:0] idx_q;

  wire tlAcc = a_valid && aReady_q;
  wire tlInRam = bms_in_range(a_address, TLRAM_BASE, TLRAM_SIZE);
  wire tlInRom = bms_in_range(a_address, ROM_BASE, ROM_SIZE);
  wire tlIsGet = a_opcode == BMS_A_GET;
  wire tlIsPut = a_opcode == BMS_A_PUT_FULL || a_opcode == BMS_A_PUT_PART;
  wire tlIsAtom = a_opcode == BMS_A_ARITH || a_opcode == BMS_A_LOGIC;
  wire tlSizeOk = a_size <= 3'(LGW);
  wire tlOpOk = tlIsGet || tlIsPut || (tlIsAtom && ATOMICS);
  wire tlRomBad = tlInRom && !tlIsGet;
  wire tlDeny = !tlSizeOk || !tlOpOk || !(tlInRam || tlInRom) ||
                tlRomBad;
  wire tlRamGo = tlAcc && !tlDeny && tlInRam;
  wire tlRomGo = tlAcc && !tlDeny && tlInRom;
  wire [31:0] tlRamOff = a_address - TLRAM_BASE;
  wire [31:0] tlRomOff = a_address - ROM_BASE;
  wire [TLRAM_AW-1:0] tlRamIdx = tlRamOff[LGW +: TLRAM_AW];
  wire [ROM_AW-1:0] tlRomIdx = tlRomOff[LGW +: ROM_AW];
  wire tlDataOp = tlIsGet || tlIsAtom;
  wire tlInRead = tlState_q == BMS_TL_READ;
  wire tlAtomOp = op_q == BMS_A_ARITH || op_q == BMS_A_LOGIC;
  wire atomWrite = tlInRead && tlAtomOp && !isRom_q;
  wire [DW-1:0] atomNew = atomicResult(op_q, param_q, tlRamBus.rdata,
                                       operand_q);
  wire [DW-1:0] tlReadWord = isRom_q ? romBus.rdata : tlRamBus.rdata;
  wire tlDone = tlState_q == BMS_TL_RESP && d_ready;

  assign tlRamBus.req = tlRamGo || atomWrite;
  assign tlRamBus.we = (tlRamGo && tlIsPut) || atomWrite;
  assign tlRamBus.idx = atomWrite ? idx_q : tlRamIdx;
  assign tlRamBus.wdata = atomWrite ? atomNew : a_data;
  assign tlRamBus.be = atomWrite ? mask_q : a_mask;

  // the read-only array has no write path at all
  assign romBus.req = tlRomGo;
  assign romBus.we = 1'b0;
  assign romBus.idx = tlRomIdx;
  assign romBus.wdata = '0;
  assign romBus.be = '0;

  // puts and denials answer at once; reads and atomics wait one cycle
  assign tlState_d = tlAcc ? ((tlDeny || tlIsPut) ? BMS_TL_RESP : BMS_TL_READ)
                   : tlInRead ? BMS_TL_RESP
                   : tlDone ? BMS_TL_IDLE : tlState_q;
  assign aReady_d = tlAcc ? 1'b0 : (tlDone ? 1'b1 : aReady_q);
  assign dValid_d = ((tlAcc && (tlDeny || tlIsPut)) || tlInRead) ? 1'b1
                  : tlDone ? 1'b0 : dValid_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tlState_q <= BMS_TL_IDLE;
      aReady_q <= BMS_RST_READY;
      dValid_q <= BMS_RST_VALID;
    end else begin
      tlState_q <= tlState_d;
      aReady_q <= aReady_d;
      dValid_q <= dValid_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dOpcode_q <= BMS_D_ACK;
      dSize_q <= '0;
      dSource_q <= '0;
      dDenied_q <= 1'b0;
      dCorrupt_q <= 1'b0;
      dData_q <= '0;
      op_q <= BMS_A_GET;
      param_q <= '0;
      operand_q <= '0;
      mask_q <= '0;
      idx_q <= '0;
      isRom_q <= 1'b0;
    end else if (tlAcc) begin
      dOpcode_q <= tlDataOp ? BMS_D_ACK_DATA : BMS_D_ACK;
      dSize_q <= a_size;
      dSource_q <= a_source;
      dDenied_q <= tlDeny;
      dCorrupt_q <= tlDeny && tlDataOp;
      dData_q <= '0;
      op_q <= a_opcode;
      param_q <= a_param;
      operand_q <= a_data;
      mask_q <= a_mask;
      idx_q <= tlRamIdx;
      isRom_q <= tlInRom;
    end else if (tlInRead) begin
      dData_q <= tlReadWord;
    end
  end

  assign a_ready = aReady_q;
  assign d_valid = dValid_q;
  assign d_opcode = dOpcode_q;
  assign d_size = dSize_q;
  assign d_source = dSource_q;
  assign d_denied = dDenied_q;
  assign d_corrupt = dCorrupt_q;
  assign d_data = dData_q;

  // AXI4-Lite side: no length or size fields, so no burst can arrive
  logic awReady_q, wReady_q, bValid_q, arReady_q, rPend_q, rValid_q;
  logic rOk_q;
  logic [1:0] bResp_q, rResp_q;
  logic [31:0] awAddr_q;
  logic [DW-1:0] wData_q, rData_q;
  logic [WIDTH_BYTES-1:0] wStrb_q;

  wire awAcc = awvalid && awReady_q;
  wire wAcc = wvalid && wReady_q;
  wire arAcc = arvalid && arReady_q;
  wire arIn = bms_in_range(araddr, AXIRAM_BASE, AXIRAM_SIZE);
  wire awIn = bms_in_range(awAddr_q, AXIRAM_BASE, AXIRAM_SIZE);
  wire wrFull = wStrb_q == FULL_STRB;
  wire [31:0] arOff = araddr - AXIRAM_BASE;
  wire [31:0] awOff = awAddr_q - AXIRAM_BASE;
  wire axRdMem = arAcc && arIn;
  // a read owns the array this cycle; the write retries on the next
  wire wrGo = !awReady_q && !wReady_q && !bValid_q && !axRdMem;
  wire wrMem = wrGo && awIn && wrFull;
  wire [1:0] wrResp = !awIn ? BMS_RESP_DECERR
                    : !wrFull ? BMS_RESP_SLVERR : BMS_RESP_OKAY;

  assign axiRamBus.req = axRdMem || wrMem;
  assign axiRamBus.we = wrMem;
  assign axiRamBus.idx = axRdMem ? arOff[LGW +: AXIRAM_AW]
                       : awOff[LGW +: AXIRAM_AW];
  assign axiRamBus.wdata = wData_q;
  assign axiRamBus.be = FULL_STRB;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awReady_q <= BMS_RST_READY;
      wReady_q <= BMS_RST_READY;
      bValid_q <= BMS_RST_VALID;
      bResp_q <= BMS_RESP_OKAY;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      if (awAcc) begin
        awReady_q <= 1'b0;
        awAddr_q <= awaddr;
      end
      if (wAcc) begin
        wReady_q <= 1'b0;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (wrGo) begin
        bValid_q <= 1'b1;
        bResp_q <= wrResp;
      end else if (bValid_q && bready) begin
        bValid_q <= 1'b0;
        awReady_q <= 1'b1;
        wReady_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arReady_q <= BMS_RST_READY;
      rPend_q <= 1'b0;
      rOk_q <= 1'b0;
      rValid_q <= BMS_RST_VALID;
      rData_q <= '0;
      rResp_q <= BMS_RESP_OKAY;
    end else begin
      rPend_q <= arAcc;
      if (arAcc) begin
        arReady_q <= 1'b0;
        rOk_q <= arIn;
      end
      if (rPend_q) begin
        rValid_q <= 1'b1;
        rData_q <= rOk_q ? axiRamBus.rdata : '0;
        rResp_q <= rOk_q ? BMS_RESP_OKAY : BMS_RESP_DECERR;
      end else if (rValid_q && rready) begin
        rValid_q <= 1'b0;
        arReady_q <= 1'b1;
      end
    end
  end

  assign awready = awReady_q;
  assign wready = wReady_q;
  assign bvalid = bValid_q;
  assign bresp = bResp_q;
  assign arready = arReady_q;
  assign rvalid = rValid_q;
  assign rdata = rData_q;
  assign rresp = rResp_q;

  logic ramCache_q, ramExec_q, romExec_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ramCache_q <= CACHEABLE;
      ramExec_q <= RAM_EXECUTABLE;
      romExec_q <= ROM_EXECUTABLE;
    end else begin
      ramCache_q <= CACHEABLE;
      ramExec_q <= RAM_EXECUTABLE;
      romExec_q <= ROM_EXECUTABLE;
    end
  end
  assign ramCacheable = ramCache_q;
  assign ramExecutable = ramExec_q;
  assign romExecutable = romExec_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  wire [31:0] romWordByte = {tlRomOff[31:LGW], {LGW{1'b0}}};
  sequence deniedAnswer;
    d_valid && d_denied;
  endsequence
  sequence arTake;
    arvalid && arready;
  endsequence

  range_deny_a: assert property (
    (tlAcc && !tlInRam && !tlInRom) |=> deniedAnswer)
    else $error("out-of-range request not denied");
  atom_off_a: assert property (
    (tlAcc && tlIsAtom && !ATOMICS) |=> deniedAnswer)
    else $error("atomic accepted while option is off");
  rom_store_a: assert property (
    (tlAcc && tlInRom && tlIsPut) |=> deniedAnswer ##0 !romBus.we)
    else $error("write to read-only memory not denied");
  one_beat_a: assert property (
    (tlAcc && a_size > 3'(LGW)) |=> deniedAnswer)
    else $error("multi-beat request not denied");
  tl_single_resp_a: assert property (
    (d_valid && d_ready) |=> (!d_valid && a_ready))
    else $error("second answer or stuck ready after response");
  rom_data_a: assert property (
    tlRomGo |-> ##2 (d_valid && !d_denied &&
      d_data[7:0] == bms_rom_byte($past(romWordByte, 2))))
    else $error("read-only data mismatch");
  axi_narrow_a: assert property (
    ($rose(bvalid) && awIn && !wrFull) |-> bresp == BMS_RESP_SLVERR)
    else $error("narrow write not answered with slave error");
  axi_read_a: assert property (
    arTake |=> !rvalid ##1 rvalid [*1])
    else $error("read answer not two cycles after address");
  attr_fixed_a: assert property (
    ramCacheable == CACHEABLE && ramExecutable == RAM_EXECUTABLE)
    else $error("memory attributes differ from configuration");
endmodule

/* File: tb/bms_tl_client.sv */
/*
  TileLink client model driving the A channel and taking the D channel.
  Assumes one caller at a time; xfer is called from the bench.
*/
`timescale 1ns/1ps
module bms_tl_client (
  input wire logic ref_clk,
  output logic a_valid,
  input wire logic a_ready,
  output logic [2:0] a_opcode,
  output logic [2:0] a_param,
  output logic [2:0] a_size,
  output logic [3:0] a_source,
  output logic [31:0] a_address,
  output logic [3:0] a_mask,
  output logic [31:0] a_data,
  input wire logic d_valid,
  output logic d_ready,
  input wire logic [2:0] d_opcode,
  input wire logic d_denied,
  input wire logic [31:0] d_data
);
  initial begin
    a_valid = 1'b0;
    a_opcode = 3'h4;
    a_param = 3'h0;
    a_size = 3'h2;
    a_source = 4'h0;
    a_address = 32'h0;
    a_mask = 4'h0;
    a_data = 32'h0;
    d_ready = 1'b0;
  end

  // released address, mask and data carry inverted junk so stale values cannot pass
  task automatic xfer(input logic [2:0] op, input logic [2:0] sz,
      input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] msk,
      output logic [2:0] dop, output logic den, output logic [31:0] dd,
      output bit hung);
    int n;
    @(posedge ref_clk);
    a_valid <= 1'b1;
    a_opcode <= op;
    a_size <= sz;
    a_source <= a_source + 4'h1;
    a_address <= adr;
    a_mask <= msk;
    a_data <= dat;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (a_ready !== 1'b1 && n < 40);
    a_valid <= 1'b0;
    a_address <= ~adr;
    a_mask <= ~msk;
    a_data <= ~dat;
    d_ready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (d_valid !== 1'b1 && n < 80);
    dop = d_opcode;
    den = d_denied;
    dd = d_data;
    d_ready <= 1'b0;
    hung = (n >= 80);
  endtask
endmodule

/* File: tb/tb_bms_top.sv */
/*
  Self-checking bench of the bus memory slave.
  Assumes the top module's default parameters.
*/
`timescale 1ns/1ps
module tb_bms_top;
  import bms_pkg::*;
  localparam logic [31:0] ROMB = 32'h100a_0000;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic a_valid, a_ready, d_valid, d_ready, d_denied, d_corrupt;
  logic [2:0] a_opcode, a_param, a_size, d_opcode, d_size;
  logic [3:0] a_source, d_source, a_mask;
  logic [31:0] a_address, a_data, d_data, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic ramCacheable, ramExecutable, romExecutable;
  int n_fail = 0;
  int n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  bms_top u_bms_top(.ref_clk(ref_clk), .resetn(resetn),
    .a_valid(a_valid), .a_ready(a_ready), .a_opcode(a_opcode),
    .a_param(a_param), .a_size(a_size), .a_source(a_source),
    .a_address(a_address), .a_mask(a_mask), .a_data(a_data),
    .d_valid(d_valid), .d_ready(d_ready), .d_opcode(d_opcode),
    .d_size(d_size), .d_source(d_source), .d_denied(d_denied),
    .d_corrupt(d_corrupt), .d_data(d_data), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .ramCacheable(ramCacheable),
    .ramExecutable(ramExecutable), .romExecutable(romExecutable));

  bms_tl_client u_bms_tl_client(.ref_clk(ref_clk), .a_valid(a_valid),
    .a_ready(a_ready), .a_opcode(a_opcode), .a_param(a_param),
    .a_size(a_size), .a_source(a_source), .a_address(a_address),
    .a_mask(a_mask), .a_data(a_data), .d_valid(d_valid),
    .d_ready(d_ready), .d_opcode(d_opcode), .d_denied(d_denied),
    .d_data(d_data));

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic hang(input int n);
    if (n >= 40) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic tl(input logic [2:0] op, input logic [2:0] sz,
      input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] msk,
      input logic [2:0] eop, input logic eden, input logic [31:0] edd);
    logic [2:0] dop;
    logic den;
    logic [31:0] dd;
    bit hung;
    u_bms_tl_client.xfer(op, sz, adr, dat, msk, dop, den, dd, hung);
    hang(hung ? 40 : 0);
    chk("d_opcode", eop, dop);
    chk("d_denied", eden, den);
    chk("d_data", edd, dd);
    chk("d_size", sz, d_size);
    chk("d_source", a_source, d_source);
    chk("d_corrupt", eden && eop == BMS_D_ACK_DATA, d_corrupt);
  endtask

  task automatic axw(input logic [31:0] adr, input logic [31:0] dat,
      input logic [3:0] stb, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= adr;
    wdata <= dat;
    wstrb <= stb;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready === 1'b1 && awvalid) begin
        awvalid <= 1'b0;
        awaddr <= ~adr;
      end
      if (wready === 1'b1 && wvalid) begin
        wvalid <= 1'b0;
        wdata <= ~dat;
      end
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    hang(n);
    chk("bresp", er, bresp);
  endtask

  task automatic axr(input logic [31:0] adr, input logic [31:0] ed,
      input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= adr;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready === 1'b1 && arvalid) begin
        arvalid <= 1'b0;
        araddr <= ~adr;
      end
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    hang(n);
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask

  task automatic sc_idle();
    chk("a_ready", 1'b1, a_ready);
    chk("d_valid", 1'b0, d_valid);
    chk("ramCacheable", 1'b1, ramCacheable);
    chk("ramExecutable", 1'b1, ramExecutable);
    chk("romExecutable", 1'b1, romExecutable);
    chk("width", 32, $bits(d_data));
  endtask

  task automatic sc_tl_ram();
    tl(BMS_A_PUT_FULL, 3'h2, 32'h1000, 32'h1234_5678, 4'hf,
      BMS_D_ACK, 1'b0, 32'h0);
    tl(BMS_A_PUT_PART, 3'h1, 32'h1000, 32'hbeef_aaaa, 4'h3,
      BMS_D_ACK, 1'b0, 32'h0);
    tl(BMS_A_GET, 3'h2, 32'h1000, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b0, 32'h1234_aaaa);
    tl(BMS_A_PUT_FULL, 3'h2, 32'h1ffc, 32'hcafe_f00d, 4'hf,
      BMS_D_ACK, 1'b0, 32'h0);
    tl(BMS_A_GET, 3'h2, 32'h1ffc, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b0, 32'hcafe_f00d);
  endtask

  // refused requests must answer and leave the stored word alone
  task automatic sc_tl_deny();
    tl(BMS_A_GET, 3'h2, 32'h2000, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b1, 32'h0);
    tl(BMS_A_GET, 3'h3, 32'h1000, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b1, 32'h0);
    tl(BMS_A_ARITH, 3'h2, 32'h1000, 32'h1, 4'hf,
      BMS_D_ACK_DATA, 1'b1, 32'h0);
    tl(BMS_A_LOGIC, 3'h2, 32'h1000, 32'hffff_ffff, 4'hf,
      BMS_D_ACK_DATA, 1'b1, 32'h0);
    tl(BMS_A_GET, 3'h2, 32'h1000, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b0, 32'h1234_aaaa);
  endtask

  task automatic sc_rom();
    tl(BMS_A_GET, 3'h2, ROMB, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b0, 32'h0302_0100);
    tl(BMS_A_GET, 3'h2, ROMB + 32'h3c, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b0, 32'h3f3e_3d3c);
    tl(BMS_A_PUT_FULL, 3'h2, ROMB, 32'hffff_ffff, 4'hf,
      BMS_D_ACK, 1'b1, 32'h0);
    tl(BMS_A_GET, 3'h2, ROMB, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b0, 32'h0302_0100);
    tl(BMS_A_GET, 3'h3, ROMB, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b1, 32'h0);
    tl(BMS_A_GET, 3'h2, ROMB + 32'h40, 32'h0, 4'hf,
      BMS_D_ACK_DATA, 1'b1, 32'h0);
  endtask

  task automatic sc_axi();
    axw(32'h2000, 32'ha5a5_0001, 4'hf, BMS_RESP_OKAY);
    axw(32'h2ffc, 32'h0bad_cafe, 4'hf, BMS_RESP_OKAY);
    axr(32'h2000, 32'ha5a5_0001, BMS_RESP_OKAY);
    axr(32'h2ffc, 32'h0bad_cafe, BMS_RESP_OKAY);
    axw(32'h2000, 32'h1111_1111, 4'h1, BMS_RESP_SLVERR);
    axr(32'h2000, 32'ha5a5_0001, BMS_RESP_OKAY);
    axw(32'h3000, 32'h0, 4'hf, BMS_RESP_DECERR);
    axr(32'h3000, 32'h0, BMS_RESP_DECERR);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    sc_idle();
    sc_tl_ram();
    sc_tl_deny();
    sc_rom();
    sc_axi();
    report_and_stop();
  end
endmodule
